// File: src/pin_mux_boot_strap_latch.sv
`timescale 1ns/1ps
`include "pin_mux_boot_strap_latch_regs.svh"
module pin_mux_boot_strap_latch
    import pin_mux_boot_strap_latch_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // strap inputs
    input  wire logic [3:0]  asyncMemCfgStrap,
    input  wire logic [1:0]  bootSelectStrap,
    input  wire logic        generalPurposeLine0,
    // software override of pin functions
    input  wire logic        swWrite,
    input  wire logic        swFlashWidthLow,
    input  wire logic        swFlashWidthHigh,
    input  wire logic [1:0]  swBa0Role,
    input  wire logic        swBusWidth8,
    // boot status
    input  wire logic        romBootActive,
    input  wire logic        bootLedOn,
    input  wire logic        bootProgress,
    // memory controller side
    input  wire logic [23:0] memByteAddr,
    input  wire logic [53:0] gpioOut,
    // memory pins
    output logic             extMemBankAddr0,
    output logic             extMemBankAddr1,
    output logic             extMemAddrBitZero,
    output logic             extMemAddr13Pin,
    output logic             extMemAddr7Pin,
    // latched configuration
    output logic [1:0]       bootSelect,
    output logic [3:0]       asyncMemCfg,
    output logic             bootCfgLine0,
    output logic             flashAddrWidthLow,
    output logic             flashAddrWidthHigh,
    output logic [1:0]       ba0RoleSel,
    output logic             memBusWidthSel,
    // camera sync pins
    input  wire logic        camMaster,
    input  wire logic        vsyncPinIn,
    input  wire logic        hsyncPinIn,
    input  wire logic        vsyncGen,
    input  wire logic        hsyncGen,
    output logic             vsyncPinOut,
    output logic             vsyncPinOe,
    output logic             hsyncPinOut,
    output logic             hsyncPinOe,
    output logic             frameStart,
    output logic             lineStart,
    input  wire logic        gateOrFieldPin,
    input  wire logic        fieldMode,
    output logic             captureGate,
    output logic             captureField,
    // video input lanes
    input  wire logic [1:0]  vinMode,
    input  wire logic [7:0]  lumaInputLane,
    input  wire logic [7:0]  chromaInputLane,
    output logic [13:0]      rawPixel,
    output logic [7:0]       ycc16Luma,
    output logic [7:0]       ycc16Chroma,
    output logic [7:0]       ycc8LaneLow,
    output logic [7:0]       ycc8LaneHigh,
    // display output pins
    input  wire logic [15:0] outSel,
    input  wire logic [7:0]  videoEncoderOut,
    input  wire logic [7:0]  gpioVout,
    input  wire logic [7:0]  pulseOut,
    input  wire logic [7:0]  realTimeOut,
    output logic [7:0]       videoOutPin,
    // serial port on chroma-4
    input  wire logic        spiCin4Mode,
    input  wire logic        serialPort2ChipSel,
    output logic             serialPort2DataIn,
    output logic             cin4PinOut,
    output logic             cin4PinOe
);
    logic   [1:0] rstSync;
    state_s       st_ff;
    state_s       nxt_st;
    logic         vsNow;
    logic         hsNow;

    // everything but the phase clears at reset (phase loads ST_RESET); straps are taken later, from the run clock
    localparam state_s ST_INIT = '{phase: ST_RESET, default: '0};

    // reset released through two flops
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rstSync <= 2'h0;
        else
            rstSync <= {rstSync[0], 1'h1};
    end

    // straps are sampled by a clocked step after release, never under reset
    always_comb
    begin
        nxt_st = st_ff;
        case (st_ff.phase)
            ST_RESET:
            begin
                // one idle edge after release lets the strap pins settle
                nxt_st.phase = ST_LATCH;
            end
            ST_LATCH:
            begin
                nxt_st.memStrap       = asyncMemCfgStrap;
                nxt_st.bootSel        = bootSelectStrap;
                nxt_st.line0Reset     = generalPurposeLine0;
                nxt_st.flashWidthLow  = asyncMemCfgStrap[0];
                nxt_st.flashWidthHigh = asyncMemCfgStrap[0];
                nxt_st.ba0Role        = asyncMemCfgStrap[2:1];
                nxt_st.busWidth8      = asyncMemCfgStrap[3];
                nxt_st.phase          = ST_RUN;
            end
            ST_RUN:
            begin
                if (swWrite)
                begin
                    nxt_st.flashWidthLow  = swFlashWidthLow;
                    nxt_st.flashWidthHigh = swFlashWidthHigh;
                    nxt_st.ba0Role        = swBa0Role;
                    nxt_st.busWidth8      = swBusWidth8;
                end
            end
            default:
            begin
                nxt_st.phase = ST_RESET;
            end
        endcase

        // sync edges become one-cycle pulses for the capture side
        nxt_st.vsPrev     = vsNow;
        nxt_st.hsPrev     = hsNow;
        nxt_st.frameStart = vsNow & ~st_ff.vsPrev;
        nxt_st.lineStart  = hsNow & ~st_ff.hsPrev;

        // field sensors never gate, so gating is held open in field mode
        if (fieldMode)
        begin
            nxt_st.captureGate  = 1'h1;
            nxt_st.captureField = gateOrFieldPin;
        end
        else
        begin
            nxt_st.captureGate  = gateOrFieldPin;
            nxt_st.captureField = 1'h0;
        end

        // each lane set updates only in its own mode and holds otherwise
        case (vinMode)
            `VIN_MODE_RAW:
            begin
                nxt_st.rawPixel = {chromaInputLane[5:0], lumaInputLane};
            end
            `VIN_MODE_YCC16:
            begin
                nxt_st.ycc16Luma   = lumaInputLane;
                nxt_st.ycc16Chroma = chromaInputLane;
            end
            `VIN_MODE_YCC8:
            begin
                nxt_st.ycc8Low  = lumaInputLane;
                nxt_st.ycc8High = chromaInputLane;
            end
            default:
            begin
                nxt_st.rawPixel = st_ff.rawPixel;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstSync[1])
    begin
        if (!rstSync[1])
            st_ff <= ST_INIT;
        else
            st_ff <= nxt_st;
    end

    assign bootSelect         = st_ff.bootSel;
    assign asyncMemCfg        = st_ff.memStrap;
    assign bootCfgLine0       = st_ff.line0Reset;
    assign flashAddrWidthLow  = st_ff.flashWidthLow;
    assign flashAddrWidthHigh = st_ff.flashWidthHigh;
    assign ba0RoleSel         = st_ff.ba0Role;
    assign memBusWidthSel     = st_ff.busWidth8;
    assign frameStart         = st_ff.frameStart;
    assign lineStart          = st_ff.lineStart;
    assign captureGate        = st_ff.captureGate;
    assign captureField       = st_ff.captureField;
    assign rawPixel           = st_ff.rawPixel;
    assign ycc16Luma          = st_ff.ycc16Luma;
    assign ycc16Chroma        = st_ff.ycc16Chroma;
    assign ycc8LaneLow        = st_ff.ycc8Low;
    assign ycc8LaneHigh       = st_ff.ycc8High;

    // bank-address-0 role; the reserved role parks the pin low
    always_comb
    begin
        case (st_ff.ba0Role)
            `BA0_ROLE_BANK:
            begin
                if (st_ff.busWidth8 == `BUS_WIDTH_16)
                begin
                    extMemBankAddr0 = 1'h0;
                end
                else
                begin
                    extMemBankAddr0 = memByteAddr[`BYTE_ADDR_BIT];
                end
            end
            `BA0_ROLE_ADDR14:
            begin
                extMemBankAddr0 = memByteAddr[`ADDR14_SRC_BIT];
            end
            `BA0_ROLE_GPIO:
            begin
                extMemBankAddr0 = gpioOut[`BA0_GPIO_BIT];
            end
            default:
            begin
                extMemBankAddr0 = 1'h0;
            end
        endcase
    end

    // halfword bit (16-bit) and second byte bit (8-bit) are the same wire
    assign extMemBankAddr1   = memByteAddr[`BANK1_ADDR_BIT];
    // the pin address counts 32-bit words whatever the bus width
    assign extMemAddrBitZero = memByteAddr[`WORD_ADDR_BIT];

    // boot status borrows two address pins while the bootloader runs
    always_comb
    begin
        if (romBootActive)
        begin
            extMemAddr13Pin = ~bootLedOn;
            extMemAddr7Pin  = bootProgress;
        end
        else
        begin
            extMemAddr13Pin = memByteAddr[`ADDR13_SRC_BIT];
            extMemAddr7Pin  = memByteAddr[`ADDR7_SRC_BIT];
        end
    end

    // camera sync direction follows master/slave mode
    assign vsNow = camMaster ? vsyncGen : vsyncPinIn;
    assign hsNow = camMaster ? hsyncGen : hsyncPinIn;

    // released pins are driven low inside so no stale level leaks out
    always_comb
    begin
        if (camMaster)
        begin
            vsyncPinOut = vsyncGen;
            hsyncPinOut = hsyncGen;
            vsyncPinOe  = 1'h1;
            hsyncPinOe  = 1'h1;
        end
        else
        begin
            vsyncPinOut = 1'h0;
            hsyncPinOut = 1'h0;
            vsyncPinOe  = 1'h0;
            hsyncPinOe  = 1'h0;
        end
    end

    // per-pin output source select
    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_vout
            always_comb
            begin
                case (outSel[2*i+1:2*i])
                    `OUT_SEL_VIDEO:
                    begin
                        videoOutPin[i] = videoEncoderOut[i];
                    end
                    `OUT_SEL_GPIO:
                    begin
                        videoOutPin[i] = gpioVout[i];
                    end
                    `OUT_SEL_PULSE:
                    begin
                        videoOutPin[i] = pulseOut[i];
                    end
                    `OUT_SEL_RTO:
                    begin
                        videoOutPin[i] = realTimeOut[i];
                    end
                    default:
                    begin
                        videoOutPin[i] = videoEncoderOut[i];
                    end
                endcase
            end
        end
    endgenerate

    // chroma-4 pin: serial data in, or drive chip select 1
    // while the pin drives chip select the data input reads low, not our own echo
    always_comb
    begin
        cin4PinOut = serialPort2ChipSel;
        if (spiCin4Mode)
        begin
            serialPort2DataIn = 1'h0;
            cin4PinOe         = 1'h1;
        end
        else
        begin
            serialPort2DataIn = chromaInputLane[4];
            cin4PinOe         = 1'h0;
        end
    end
endmodule // pin_mux_boot_strap_latch

// File: src/pin_mux_boot_strap_latch_regs.svh
`ifndef PIN_MUX_BOOT_STRAP_LATCH_REGS_SVH
`define PIN_MUX_BOOT_STRAP_LATCH_REGS_SVH
`define BA0_ROLE_BANK     2'h0
`define BA0_ROLE_ADDR14   2'h1
`define BA0_ROLE_GPIO     2'h2
`define BUS_WIDTH_16      1'h0
`define VIN_MODE_RAW      2'h0
`define VIN_MODE_YCC16    2'h1
`define VIN_MODE_YCC8     2'h2
`define OUT_SEL_VIDEO     2'h0
`define OUT_SEL_GPIO      2'h1
`define OUT_SEL_PULSE     2'h2
`define OUT_SEL_RTO       2'h3
`define BYTE_ADDR_BIT     0
`define BANK1_ADDR_BIT    1
`define WORD_ADDR_BIT     2
`define ADDR7_SRC_BIT     9
`define ADDR13_SRC_BIT    15
`define ADDR14_SRC_BIT    16
`define BA0_GPIO_BIT      53
`endif

// File: src/pin_mux_boot_strap_latch_pkg.sv
package pin_mux_boot_strap_latch_pkg;
    typedef enum logic [2:0] {
        ST_RESET = 3'h1,
        ST_LATCH = 3'h2,
        ST_RUN   = 3'h4
    } phase_e;
    typedef struct packed {
        phase_e     phase;
        logic [3:0] memStrap;
        logic [1:0] bootSel;
        logic       line0Reset;
        logic       flashWidthLow;
        logic       flashWidthHigh;
        logic [1:0] ba0Role;
        logic       busWidth8;
        logic       vsPrev;
        logic       hsPrev;
        logic       frameStart;
        logic       lineStart;
        logic       captureGate;
        logic       captureField;
        logic [13:0] rawPixel;
        logic [7:0] ycc16Luma;
        logic [7:0] ycc16Chroma;
        logic [7:0] ycc8Low;
        logic [7:0] ycc8High;
    } state_s;
endpackage

// File: verification/pin_mux_boot_strap_latch_props.sv
`timescale 1ns/1ps
`include "pin_mux_boot_strap_latch_regs.svh"
module pin_mux_boot_strap_latch_props
(
    // watched ports
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic [23:0] memByteAddr,
    input wire logic [53:0] gpioOut,
    input wire logic        romBootActive,
    input wire logic        bootLedOn,
    input wire logic        camMaster,
    input wire logic        vsyncPinIn,
    input wire logic        spiCin4Mode,
    input wire logic        extMemBankAddr0,
    input wire logic        extMemBankAddr1,
    input wire logic        extMemAddrBitZero,
    input wire logic        extMemAddr13Pin,
    input wire logic [1:0]  ba0RoleSel,
    input wire logic        vsyncPinOe,
    input wire logic        frameStart,
    input wire logic [3:0]  asyncMemCfg,
    input wire logic [1:0]  bootSelect,
    input wire logic        cin4PinOe
);
    logic [2:0] upCnt_ff;
    logic [2:0] nxt_upCnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // saturates well after the strap sampling edge
    assign nxt_upCnt = (upCnt_ff == 3'h7) ? upCnt_ff : upCnt_ff + 3'h1;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            upCnt_ff <= 3'h0;
        else
            upCnt_ff <= nxt_upCnt;
    end
    chk_word_addr: assert property (extMemAddrBitZero == memByteAddr[2])
        else $error("word address pin wrong");
    chk_bank_one: assert property (extMemBankAddr1 == memByteAddr[1])
        else $error("bank address one wrong");
    chk_ba0_a14: assert property (ba0RoleSel == `BA0_ROLE_ADDR14 |-> extMemBankAddr0 == memByteAddr[16])
        else $error("bank pin not address 14");
    chk_ba0_gpio: assert property (ba0RoleSel == `BA0_ROLE_GPIO |-> extMemBankAddr0 == gpioOut[53])
        else $error("bank pin not gpio line");
    chk_boot_led: assert property (romBootActive |-> extMemAddr13Pin == !bootLedOn)
        else $error("boot led level wrong");
    chk_sync_dir: assert property (vsyncPinOe == camMaster)
        else $error("vertical sync direction wrong");
    chk_frame_start: assert property (!camMaster && $rose(vsyncPinIn) |-> ##[1:3] frameStart)
        else $error("frame start missing");
    chk_frame_pulse: assert property (frameStart |=> !frameStart)
        else $error("frame start too long");
    chk_straps_held: assert property (upCnt_ff == 3'h7 |-> $stable(asyncMemCfg) && $stable(bootSelect))
        else $error("strap capture changed");
    chk_cin4_dir: assert property (cin4PinOe == spiCin4Mode)
        else $error("chroma four direction wrong");
    cov_frame: cover property (frameStart);
    cov_led: cover property (romBootActive && !bootLedOn);
    cov_a14: cover property (ba0RoleSel == `BA0_ROLE_ADDR14);
endmodule // pin_mux_boot_strap_latch_props
bind pin_mux_boot_strap_latch pin_mux_boot_strap_latch_props props (.*);

// File: verification/sensor_front_end_model.sv
`timescale 1ns/1ps
module sensor_front_end_model
(
    // clock and frame command
    input  wire logic  core_clk,
    input  wire logic  frameReq,
    // sensor pins
    output logic       vsyncOut,
    output logic [7:0] lumaOut,
    output logic [7:0] chromaOut,
    output logic       hsyncOut
);
    logic [7:0] pixCnt_ff = 8'h00;
    always_ff @(posedge core_clk)
    begin
        pixCnt_ff <= frameReq ? pixCnt_ff + 8'h01 : 8'h00;
    end
    assign vsyncOut  = frameReq && pixCnt_ff == 8'h00;
    assign hsyncOut  = frameReq && pixCnt_ff[1:0] == 2'h0;
    // idle luma lane shows the inverted count (chroma the plain count) so stale data cannot pass
    assign lumaOut   = frameReq ? pixCnt_ff : ~pixCnt_ff;
    assign chromaOut = ~lumaOut;
endmodule // sensor_front_end_model

// File: verification/testbench.sv
`timescale 1ns/1ps
`include "pin_mux_boot_strap_latch_regs.svh"
module testbench;
    logic        core_clk = 1'b0, rst_b, swWrite, swFlashWidthLow, swFlashWidthHigh, swBusWidth8;
    logic        generalPurposeLine0, romBootActive, bootLedOn, bootProgress, camMaster;
    logic        vsyncPinIn, hsyncPinIn, vsyncGen, hsyncGen, gateOrFieldPin, fieldMode;
    logic        spiCin4Mode, serialPort2ChipSel, frameReq, extMemAddr7Pin, cin4PinOut;
    logic        extMemBankAddr0, extMemBankAddr1, extMemAddrBitZero, extMemAddr13Pin;
    logic        bootCfgLine0, flashAddrWidthLow, flashAddrWidthHigh, memBusWidthSel;
    logic        vsyncPinOut, vsyncPinOe, hsyncPinOut, hsyncPinOe, frameStart, lineStart;
    logic        captureGate, captureField, serialPort2DataIn, cin4PinOe;
    logic [1:0]  bootSelectStrap, swBa0Role, bootSelect, ba0RoleSel, vinMode;
    logic [3:0]  asyncMemCfgStrap, asyncMemCfg;
    logic [7:0]  lumaInputLane, chromaInputLane, ycc16Luma, ycc16Chroma, ycc8LaneLow;
    logic [7:0]  ycc8LaneHigh, videoEncoderOut, gpioVout, pulseOut, realTimeOut, videoOutPin;
    logic [13:0] rawPixel;
    logic [15:0] outSel;
    logic [23:0] memByteAddr;
    logic [53:0] gpioOut;
    int          err_total = 0, n_tests = 0;
    pin_mux_boot_strap_latch dut (.*);
    sensor_front_end_model sfe (.core_clk(core_clk), .frameReq(frameReq), .vsyncOut(vsyncPinIn),
        .hsyncOut(hsyncPinIn), .lumaOut(lumaInputLane), .chromaOut(chromaInputLane));
    // the 200 MHz core clock also stands in for the external video clock
    always #2.5 core_clk = ~core_clk;
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_straps;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge core_clk);
            rst_b <= 1'b0;
            {asyncMemCfgStrap, bootSelectStrap, generalPurposeLine0} <= {i[0], i[1:0], ~i[0], i[1:0], i[0]};
            repeat (8) @(posedge core_clk);
            rst_b <= 1'b1;
            repeat (6) @(posedge core_clk);
            #1;
            cmp({bootSelect, asyncMemCfg}, {i[1:0], i[0], i[1:0], ~i[0]});
            cmp({flashAddrWidthLow, flashAddrWidthHigh}, {2{~i[0]}});
            cmp({ba0RoleSel, memBusWidthSel, bootCfgLine0}, {i[1:0], i[0], i[0]});
            @(posedge core_clk);
            {asyncMemCfgStrap, bootSelectStrap} <= ~{asyncMemCfgStrap, bootSelectStrap};
            repeat (3) @(posedge core_clk);
            #1;
            cmp({bootSelect, asyncMemCfg}, {i[1:0], i[0], i[1:0], ~i[0]});
        end
        $display("straps test done");
    endtask
    task automatic t_addr;
        for (int r = 0; r < 5; r++)
        begin
            @(posedge core_clk);
            {swWrite, swBa0Role, swBusWidth8, swFlashWidthLow, swFlashWidthHigh} <= {1'b1, r[1:0], ~r[2], r[1:0]};
            memByteAddr <= {7'h0, r[0], 13'h0, ~r[1], r[0], ~r[1]};
            gpioOut <= {~r[0], 53'h0};
            @(posedge core_clk);
            swWrite <= 1'b0;
            @(posedge core_clk);
            #1;
            cmp({ba0RoleSel, memBusWidthSel, flashAddrWidthLow, flashAddrWidthHigh}, {r[1:0], ~r[2], r[1:0]});
            cmp(extMemBankAddr0, r == 0 ? memByteAddr[0] : r == 1 ? memByteAddr[16] : r == 2 ? gpioOut[53] : 1'b0);
            cmp({extMemBankAddr1, extMemAddrBitZero}, {memByteAddr[1], memByteAddr[2]});
        end
        $display("address test done");
    endtask
    task automatic t_boot;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge core_clk);
            {romBootActive, bootLedOn, bootProgress} <= {i < 4, i[1:0]};
            memByteAddr <= {8'h0, i[0], 5'h0, ~i[0], 9'h0};
            #1;
            cmp({extMemAddr13Pin, extMemAddr7Pin}, i < 4 ? {~i[1], i[0]} : {memByteAddr[15], memByteAddr[9]});
        end
        $display("boot status test done");
    endtask
    task automatic t_sync;
        int nf;
        int nl;
        for (int m = 0; m < 2; m++)
        begin
            {nf, nl} = '0;
            @(posedge core_clk);
            camMaster <= m[0];
            for (int k = 0; k < 14; k++)
            begin
                @(posedge core_clk);
                frameReq <= !m[0] && k < 8;
                {vsyncGen, hsyncGen} <= {2{m[0] && k < 2}};
                #1;
                nf += frameStart;
                nl += lineStart;
                if (k == 0)
                    cmp({vsyncPinOe, hsyncPinOe, vsyncPinOut & m[0]}, {3{m[0]}});
            end
            cmp({nf[7:0], nl[7:0]}, {8'h1, 8'h2 - m[7:0]});
        end
        $display("sync test done");
    endtask
    task automatic t_video;
        logic [7:0] l;
        logic [7:0] c;
        for (int m = 0; m < 3; m++)
        begin
            @(posedge core_clk);
            {vinMode, fieldMode, gateOrFieldPin, frameReq} <= {m[1:0], m[0], m != 0, 1'b1};
            @(negedge core_clk);
            {l, c} = {lumaInputLane, chromaInputLane};
            @(posedge core_clk);
            #1;
            cmp(m == 0 ? {2'h0, rawPixel} : m == 1 ? {ycc16Luma, ycc16Chroma} : {ycc8LaneLow, ycc8LaneHigh},
                m == 0 ? {2'h0, c[5:0], l} : {l, c});
            cmp({captureGate, captureField}, {m != 0, m == 1});
        end
        $display("video input test done");
    endtask
    task automatic t_vout;
        logic [15:0] sels [5] = '{16'h0000, 16'h5555, 16'haaaa, 16'hffff, 16'he4e4};
        logic [7:0]  exps [5] = '{8'h11, 8'h22, 8'h44, 8'h88, 8'hff};
        for (int i = 0; i < 5; i++)
        begin
            @(posedge core_clk);
            {outSel, spiCin4Mode, serialPort2ChipSel} <= {sels[i], i[0], i[1]};
            #1;
            cmp(videoOutPin, exps[i]);
            cmp({cin4PinOe, i[0] ? cin4PinOut : serialPort2DataIn}, {i[0], i[0] ? i[1] : chromaInputLane[4]});
        end
        $display("output pin test done");
    endtask
    initial
    begin
        {rst_b, swWrite, swFlashWidthLow, swFlashWidthHigh, swBusWidth8, generalPurposeLine0} = '0;
        {romBootActive, bootLedOn, bootProgress, camMaster, vsyncGen, hsyncGen} = '0;
        {gateOrFieldPin, fieldMode, spiCin4Mode, serialPort2ChipSel, frameReq, swBa0Role} = '0;
        {vinMode, asyncMemCfgStrap, bootSelectStrap, outSel, memByteAddr, gpioOut} = '0;
        {videoEncoderOut, gpioVout, pulseOut, realTimeOut} = 32'h11224488;
        t_straps;
        t_addr;
        t_boot;
        t_sync;
        t_video;
        t_vout;
        end_sim;
    end
    // whole run needs well under a thousand cycles
    initial
    begin
        #20000;
        err_total++;
        end_sim;
    end
endmodule // testbench
